// ===== kbio_ports.sv
// Five keyboard I/O ports on the CPU data memory, wake-up and edge irq.
`include "kbio_map.svh"

module kbio_ports #(
   parameter kbio_pkg::kbio_byte_type PULLUP_A = 8'hff,
   parameter kbio_pkg::kbio_byte_type PULLUP_B = 8'hff,
   parameter kbio_pkg::kbio_byte_type PULLUP_C = 8'hff,
   parameter kbio_pkg::kbio_byte_type PULLUP_D = 8'hff,
   parameter kbio_pkg::kbio_e_type    PULLUP_E = 5'h1f,
   parameter kbio_pkg::kbio_byte_type WAKE_A   = 8'hff,
   parameter kbio_pkg::kbio_byte_type WAKE_C   = 8'h0f
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              chip_reset,
   input  wire logic              halt,
   input  wire logic              mem_wr,
   input  wire logic              mem_rd,
   input  wire kbio_pkg::kbio_byte_type mem_addr,
   input  wire kbio_pkg::kbio_byte_type mem_wdata,
   output kbio_pkg::kbio_byte_type     mem_rdata,
   output logic                  wake,
   output logic                  ext_irq_req,
   input  wire logic              ext_irq_ack,
   input  wire kbio_pkg::kbio_byte_type port_a_pad_in,
   output kbio_pkg::kbio_byte_type     port_a_pad_out,
   output kbio_pkg::kbio_byte_type     port_a_pad_oe,
   output kbio_pkg::kbio_byte_type     port_a_pullup,
   input  wire kbio_pkg::kbio_byte_type port_b_pad_in,
   output kbio_pkg::kbio_byte_type     port_b_pad_out,
   output kbio_pkg::kbio_byte_type     port_b_pad_oe,
   output kbio_pkg::kbio_byte_type     port_b_pullup,
   input  wire kbio_pkg::kbio_byte_type port_c_pad_in,
   output kbio_pkg::kbio_byte_type     port_c_pad_out,
   output kbio_pkg::kbio_byte_type     port_c_pad_oe,
   output kbio_pkg::kbio_byte_type     port_c_pullup,
   input  wire kbio_pkg::kbio_byte_type port_d_pad_in,
   output kbio_pkg::kbio_byte_type     port_d_pad_out,
   output kbio_pkg::kbio_byte_type     port_d_pad_oe,
   output kbio_pkg::kbio_byte_type     port_d_pullup,
   input  wire kbio_pkg::kbio_e_type    port_e_pad_in,
   output kbio_pkg::kbio_e_type        port_e_pad_out,
   output kbio_pkg::kbio_e_type        port_e_pad_oe,
   output kbio_pkg::kbio_e_type        port_e_pullup
);
   import kbio_pkg::*;

   // ========================================================================
   // Port slices
   kbio_port_if #(.W(8)) a_if ();
   kbio_port_if #(.W(8)) b_if ();
   kbio_port_if #(.W(8)) c_if ();
   kbio_port_if #(.W(8)) d_if ();
   kbio_port_if #(.W(5)) e_if ();

   kbio_byte_type next_rdata;
   kbio_byte_type wake_prev;
   kbio_byte_type wake_c_prev;
   kbio_byte_type wake_fall;
   logic          irq_prev;
   logic          irq_edge;
   logic          edge_rise;

   // Thirty-seven lines, each usable both ways except port E lines 2 to 4, which are output only.
   kbio_port #(.W(8), .RST(`KBIO_RST_FULL), .PU(PULLUP_A),
               .OD(8'h00), .OUT(8'h00))
      u_port_a (.sys_clk(sys_clk), .rst_b(rst_b), .pif(a_if));
   kbio_port #(.W(8), .RST(`KBIO_RST_FULL), .PU(PULLUP_B),
               .OD(8'h00), .OUT(8'h00))
      u_port_b (.sys_clk(sys_clk), .rst_b(rst_b), .pif(b_if));
   kbio_port #(.W(8), .RST(`KBIO_RST_FULL), .PU(PULLUP_C),
               .OD(`KBIO_OD_MASK), .OUT(8'h00))
      u_port_c (.sys_clk(sys_clk), .rst_b(rst_b), .pif(c_if));
   kbio_port #(.W(8), .RST(`KBIO_RST_FULL), .PU(PULLUP_D),
               .OD(8'h00), .OUT(8'h00))
      u_port_d (.sys_clk(sys_clk), .rst_b(rst_b), .pif(d_if));
   kbio_port #(.W(5), .RST(`KBIO_RST_E), .PU(PULLUP_E),
               .OD(5'h00), .OUT(`KBIO_LED_MASK))
      u_port_e (.sys_clk(sys_clk), .rst_b(rst_b), .pif(e_if));

   // ========================================================================
   // Write decode: data and direction registers on the data memory.
   assign a_if.data_we = mem_wr && (mem_addr == `KBIO_A_DATA_OFS);
   assign b_if.data_we = mem_wr && (mem_addr == `KBIO_B_DATA_OFS);
   assign c_if.data_we = mem_wr && (mem_addr == `KBIO_C_DATA_OFS);
   assign d_if.data_we = mem_wr && (mem_addr == `KBIO_D_DATA_OFS);
   assign e_if.data_we = mem_wr && (mem_addr == `KBIO_E_DATA_OFS);
   assign a_if.dir_we  = mem_wr && (mem_addr == `KBIO_A_DIR_OFS);
   assign b_if.dir_we  = mem_wr && (mem_addr == `KBIO_B_DIR_OFS);
   assign c_if.dir_we  = mem_wr && (mem_addr == `KBIO_C_DIR_OFS);
   assign d_if.dir_we  = mem_wr && (mem_addr == `KBIO_D_DIR_OFS);
   assign e_if.dir_we  = mem_wr && (mem_addr == `KBIO_E_DIR_OFS);

   // Write data and the synchronous chip reset reach every slice.
   // A watchdog warm reset in halt has no input here, so it leaves
   // every latch and direction register alone.
   assign a_if.wdata = mem_wdata;
   assign b_if.wdata = mem_wdata;
   assign c_if.wdata = mem_wdata;
   assign d_if.wdata = mem_wdata;
   assign e_if.wdata = mem_wdata[4:0];
   assign a_if.init  = chip_reset;
   assign b_if.init  = chip_reset;
   assign c_if.init  = chip_reset;
   assign d_if.init  = chip_reset;
   assign e_if.init  = chip_reset;

   // Pads enter the slices, drive comes back out from slice flops.
   assign a_if.pad_in   = port_a_pad_in;
   assign b_if.pad_in   = port_b_pad_in;
   assign c_if.pad_in   = port_c_pad_in;
   assign d_if.pad_in   = port_d_pad_in;
   assign e_if.pad_in   = port_e_pad_in;
   assign port_a_pad_out = a_if.pad_out;
   assign port_a_pad_oe  = a_if.pad_oe;
   assign port_a_pullup  = a_if.pull_en;
   assign port_b_pad_out = b_if.pad_out;
   assign port_b_pad_oe  = b_if.pad_oe;
   assign port_b_pullup  = b_if.pull_en;
   assign port_c_pad_out = c_if.pad_out;
   assign port_c_pad_oe  = c_if.pad_oe;
   assign port_c_pullup  = c_if.pull_en;
   assign port_d_pad_out = d_if.pad_out;
   assign port_d_pad_oe  = d_if.pad_oe;
   assign port_d_pullup  = d_if.pull_en;
   assign port_e_pad_out = e_if.pad_out;
   assign port_e_pad_oe  = e_if.pad_oe;
   assign port_e_pullup  = e_if.pull_en;

   // ========================================================================
   // Read path: pad level sampled at the read, latch for output lines.
   // Read-modify-write bit instructions rely on output lines reading back
   // their latch, so the write-back leaves other output bits unchanged.
   always_comb
   begin
      next_rdata = `KBIO_RD_NONE;
      case (mem_addr)
         `KBIO_A_DATA_OFS: next_rdata = a_if.rd_val;
         `KBIO_B_DATA_OFS: next_rdata = b_if.rd_val;
         `KBIO_C_DATA_OFS: next_rdata = c_if.rd_val;
         `KBIO_D_DATA_OFS: next_rdata = d_if.rd_val;
         `KBIO_E_DATA_OFS: next_rdata = {3'b000, e_if.rd_val};
         `KBIO_A_DIR_OFS:  next_rdata = a_if.dir;
         `KBIO_B_DIR_OFS:  next_rdata = b_if.dir;
         `KBIO_C_DIR_OFS:  next_rdata = c_if.dir;
         `KBIO_D_DIR_OFS:  next_rdata = d_if.dir;
         `KBIO_E_DIR_OFS:  next_rdata = {3'b000, e_if.dir};
         default:          next_rdata = `KBIO_RD_NONE;
      endcase
   end

   // Read data is registered and held until the next read.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         mem_rdata <= `KBIO_RD_NONE;
      else if (mem_rd)
         mem_rdata <= next_rdata;
   end

   // ========================================================================
   // Wake-up: falling edge on an enabled line while halted.
   assign wake_fall = (wake_prev & ~a_if.pad_sync & WAKE_A)
                    | (wake_c_prev & ~c_if.pad_sync
                       & WAKE_C & `KBIO_WAKE_C_CAP);

   // Previous synced levels for falling-edge detection.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wake_prev   <= 8'hff;
         wake_c_prev <= 8'hff;
      end
      else
      begin
         wake_prev   <= a_if.pad_sync;
         wake_c_prev <= c_if.pad_sync;
      end
   end

   // One-cycle wake pulse; the core resumes at the next instruction.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         wake <= 1'b0;
      else
         wake <= halt && (wake_fall != 8'h00);
   end

   // ========================================================================
   // External interrupt: edge chosen by the edge-select line latch.
   assign edge_rise = e_if.latch[`KBIO_EDGE_LINE];
   assign irq_edge  = edge_rise
                    ? (!irq_prev && c_if.pad_sync[`KBIO_IRQ_LINE])
                    : (irq_prev && !c_if.pad_sync[`KBIO_IRQ_LINE]);

   // Previous synced level of the interrupt line.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         irq_prev <= 1'b1;
      else
         irq_prev <= c_if.pad_sync[`KBIO_IRQ_LINE];
   end

   // Request flag: an edge in the acknowledge cycle is kept.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         ext_irq_req <= 1'b0;
      else if (irq_edge)
         ext_irq_req <= 1'b1;
      else if (ext_irq_ack)
         ext_irq_req <= 1'b0;
   end

   // ========================================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence seq_irq_rise;
      edge_rise && !irq_prev && c_if.pad_sync[`KBIO_IRQ_LINE];
   endsequence

   sequence seq_irq_fall;
      !edge_rise && irq_prev && !c_if.pad_sync[`KBIO_IRQ_LINE];
   endsequence

   chk_irq_rising: assert property (seq_irq_rise |=> ext_irq_req)
      else $error("Rising edge did not raise the request.");
   chk_irq_falling: assert property (seq_irq_fall |=> ext_irq_req)
      else $error("Falling edge did not raise the request.");
   chk_irq_wrong_edge: assert property (
      !ext_irq_req && !irq_edge |=> !ext_irq_req)
      else $error("Request raised without a selected edge.");
   chk_wake_pulse: assert property (
      halt && (wake_fall != 8'h00) |=> wake)
      else $error("Enabled falling edge in halt did not wake.");
   chk_wake_idle: assert property (!halt |=> !wake)
      else $error("Wake pulse outside halt.");
   chk_read_input: assert property (
      mem_rd && (mem_addr == `KBIO_B_DATA_OFS) && (b_if.dir == 8'hff)
      |=> mem_rdata == $past(b_if.pad_sync))
      else $error("Input read did not return the pad level.");
   chk_read_latch: assert property (
      mem_rd && (mem_addr == `KBIO_D_DATA_OFS) && (d_if.dir == 8'h00)
      |=> mem_rdata == $past(d_if.latch))
      else $error("Output read did not return the latch.");
   chk_unmapped_zero: assert property (
      mem_rd && (mem_addr < `KBIO_A_DATA_OFS) |=> mem_rdata == 8'h00)
      else $error("Unmapped read returned data.");
   chk_od_low_only: assert property (
      ##1 (port_c_pad_out[1:0] == 2'b00))
      else $error("Open-drain line driven high.");
   chk_reset_ones: assert property (
      chip_reset |=> (a_if.dir == 8'hff) ##1 (port_a_pad_oe == 8'h00))
      else $error("Reset did not return lines to input.");
endmodule : kbio_ports

// ===== kbio_map.svh
// Register offsets, reset values and line positions of the keyboard ports.
`ifndef KBIO_MAP_SVH
`define KBIO_MAP_SVH

// ==========================================================================
// Data memory offsets
`define KBIO_A_DATA_OFS 8'h12
`define KBIO_A_DIR_OFS  8'h13
`define KBIO_B_DATA_OFS 8'h14
`define KBIO_B_DIR_OFS  8'h15
`define KBIO_C_DATA_OFS 8'h16
`define KBIO_C_DIR_OFS  8'h17
`define KBIO_D_DATA_OFS 8'h18
`define KBIO_D_DIR_OFS  8'h19
`define KBIO_E_DATA_OFS 8'h1a
`define KBIO_E_DIR_OFS  8'h1b

// ==========================================================================
// Reset values and line positions
`define KBIO_RST_FULL   8'hff
`define KBIO_RST_E      5'h1f
`define KBIO_IRQ_LINE   2
`define KBIO_EDGE_LINE  0
`define KBIO_OD_MASK    8'h03
`define KBIO_LED_MASK   5'h1c
`define KBIO_WAKE_C_CAP 8'h0f
`define KBIO_RD_NONE    8'h00

`endif

// ===== kbio_pkg.sv
// Types shared by the keyboard port block.
package kbio_pkg;

   typedef logic [7:0] kbio_byte_type;
   typedef logic [4:0] kbio_e_type;

endpackage : kbio_pkg

// ===== kbio_port_if.sv
// Signals between the register decode and one port slice.
interface kbio_port_if #(parameter int W = 8);
   logic         data_we;
   logic         dir_we;
   logic         init;
   logic [W-1:0] wdata;
   logic [W-1:0] latch;
   logic [W-1:0] dir;
   logic [W-1:0] pad_in;
   logic [W-1:0] pad_sync;
   logic [W-1:0] rd_val;
   logic [W-1:0] pad_out;
   logic [W-1:0] pad_oe;
   logic [W-1:0] pull_en;

   modport ctrl (output data_we, dir_we, init, wdata, pad_in,
                 input  latch, dir, pad_sync, rd_val, pad_out, pad_oe,
                        pull_en);
   modport port (input  data_we, dir_we, init, wdata, pad_in,
                 output latch, dir, pad_sync, rd_val, pad_out, pad_oe,
                        pull_en);
endinterface : kbio_port_if

// ===== kbio_port.sv
// One port slice: data latch, direction register, pad sync and drive.
module kbio_port #(
   parameter int           W   = 8,
   parameter logic [W-1:0] RST = '1,
   parameter logic [W-1:0] PU  = '0,
   parameter logic [W-1:0] OD  = '0,
   parameter logic [W-1:0] OUT = '0
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   kbio_port_if.port pif
);
   import kbio_pkg::*;

   logic [W-1:0] sync1;

   // Output latch holds until rewritten; chip reset sets all ones.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         pif.latch <= RST;
      else if (pif.init)
         pif.latch <= RST;
      else if (pif.data_we)
         pif.latch <= pif.wdata;
   end

   // Direction bit of one makes a line an input.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         pif.dir <= RST;
      else if (pif.init)
         pif.dir <= RST;
      else if (pif.dir_we)
         pif.dir <= pif.wdata;
   end

   // Pads come from outside the clock domain: two flops first.
   // Both flops reset to the idle high level, so the edge detectors
   // downstream see no false edge as the pulled-up pads arrive.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync1        <= RST;
         pif.pad_sync <= RST;
      end
      else
      begin
         sync1        <= pif.pad_in;
         pif.pad_sync <= sync1;
      end
   end

   // Input lines show the pad, output lines the latch.
   assign pif.rd_val = ((~pif.dir | OUT) & pif.latch)
                     | (pif.dir & ~OUT & pif.pad_sync);

   // Pad drive: push-pull, open-drain low only, output-only lines.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pif.pad_out <= RST & ~OD;
         pif.pad_oe  <= OUT;
         pif.pull_en <= PU & ~OUT;
      end
      else
      begin
         pif.pad_out <= pif.latch & ~OD;
         pif.pad_oe  <= OUT | (~pif.dir & ~OD)
                      | (~pif.dir & OD & ~pif.latch);
         pif.pull_en <= pif.dir & PU & ~OUT;
      end
   end

   // ========================================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   chk_latch_hold: assert property (
      !pif.data_we && !pif.init |=> $stable(pif.latch))
      else $error("Port latch changed without a write.");
   chk_init_ones: assert property (
      pif.init |=> (pif.latch == RST) && (pif.dir == RST))
      else $error("Chip reset did not set port to ones.");
   chk_drive_dir: assert property (
      (pif.dir == '0) && (OD == '0)
      |=> (pif.pad_oe == '1) && (pif.pad_out == $past(pif.latch)))
      else $error("Output line not driving its latch.");
endmodule : kbio_port

// ===== kbio_pad_model.sv
// Far-side model of one port: key matrix, LEDs and PS2 pull-ups.
module kbio_pad_model #(
   parameter int           W      = 8,
   parameter logic [W-1:0] EXT_PU = '0
) (
   input  wire logic         sys_clk,
   input  wire logic [W-1:0] pad_out,
   input  wire logic [W-1:0] pad_oe,
   input  wire logic [W-1:0] pull_en,
   input  wire logic [W-1:0] key_val,
   input  wire logic         key_en,
   output logic [W-1:0]      pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] drift = '0;

   // A line that nobody drives or pulls wanders every cycle.
   always @(posedge sys_clk)
   begin
      drift <= ~drift;
   end

   // Device drive wins, then a pressed key, then a pull-up.
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         if (pad_oe[i])
            pad_in[i] = pad_out[i];
         else if (key_en)
            pad_in[i] = key_val[i];
         else if (pull_en[i] | EXT_PU[i])
            pad_in[i] = 1'b1;
         else
            pad_in[i] = drift[i];
      end
   end
endmodule : kbio_pad_model

// ===== kbio_ports_tb.sv
// Self-checking bench for the five keyboard I/O ports.
`include "kbio_map.svh"
module kbio_ports_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import kbio_pkg::*;
   logic          sys_clk, rst_b, chip_reset, halt, mem_wr, mem_rd;
   logic          ext_irq_ack, wake, ext_irq_req;
   kbio_byte_type mem_addr, mem_wdata, mem_rdata;
   kbio_byte_type key_val[5], pin[4], po[5], oe[5], pu[5];
   logic          key_en[5];
   kbio_e_type    e_in, e_out, e_oe, e_pu;
   int            miscompares = 0;
   int            checks_done = 0;
   int            cycles = 0;

   // ======================================================================
   // Device, far-side models and clock
   assign po[4] = {3'h0, e_out};
   assign oe[4] = {3'h0, e_oe};
   assign pu[4] = {3'h0, e_pu};
   kbio_ports i_kbio_ports (.sys_clk(sys_clk), .rst_b(rst_b),
      .chip_reset(chip_reset), .halt(halt), .mem_wr(mem_wr),
      .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .wake(wake), .ext_irq_req(ext_irq_req),
      .ext_irq_ack(ext_irq_ack), .port_a_pad_in(pin[0]),
      .port_a_pad_out(po[0]), .port_a_pad_oe(oe[0]),
      .port_a_pullup(pu[0]), .port_b_pad_in(pin[1]),
      .port_b_pad_out(po[1]), .port_b_pad_oe(oe[1]),
      .port_b_pullup(pu[1]), .port_c_pad_in(pin[2]),
      .port_c_pad_out(po[2]), .port_c_pad_oe(oe[2]),
      .port_c_pullup(pu[2]), .port_d_pad_in(pin[3]),
      .port_d_pad_out(po[3]), .port_d_pad_oe(oe[3]),
      .port_d_pullup(pu[3]), .port_e_pad_in(e_in), .port_e_pad_out(e_out),
      .port_e_pad_oe(e_oe), .port_e_pullup(e_pu));
   for (genvar g = 0; g < 4; g++)
   begin : g_pad
      kbio_pad_model #(.W(8), .EXT_PU(g == 2 ? 8'h03 : 8'h00))
         i_kbio_pad_model (.sys_clk(sys_clk), .pad_out(po[g]),
         .pad_oe(oe[g]), .pull_en(pu[g]), .key_val(key_val[g]),
         .key_en(key_en[g]), .pad_in(pin[g]));
   end
   kbio_pad_model #(.W(5)) i_kbio_pad_model (.sys_clk(sys_clk),
      .pad_out(e_out), .pad_oe(e_oe), .pull_en(e_pu),
      .key_val(key_val[4][4:0]), .key_en(key_en[4]), .pad_in(e_in));

   // Free-running system clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ======================================================================
   // Helpers
   function automatic kbio_byte_type ofs(input int i);
      return `KBIO_A_DATA_OFS + 8'(2 * i);
   endfunction : ofs
   function automatic kbio_byte_type msk(input int i);
      return (i == 4) ? 8'h1f : 8'hff;
   endfunction : msk
   task automatic check(input string what, input kbio_byte_type seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wait_n(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wait_n
   task automatic wr(input kbio_byte_type a, d);
      @(negedge sys_clk);
      mem_wr = 1'b1;
      mem_addr = a;
      mem_wdata = d;
      @(negedge sys_clk);
      mem_wr = 1'b0;
   endtask : wr
   task automatic rdx(input kbio_byte_type a, output kbio_byte_type d);
      @(negedge sys_clk);
      mem_rd = 1'b1;
      mem_addr = a;
      @(negedge sys_clk);
      mem_rd = 1'b0;
      d = mem_rdata;
   endtask : rdx
   task automatic rck(input string what, input kbio_byte_type a, exp);
      kbio_byte_type d;
      rdx(a, d);
      check(what, d, exp);
   endtask : rck
   task automatic ack_irq;
      @(negedge sys_clk);
      ext_irq_ack = 1'b1;
      @(negedge sys_clk);
      ext_irq_ack = 1'b0;
      @(negedge sys_clk);
   endtask : ack_irq

   // ======================================================================
   // Scenarios
   task automatic t_reset_state;
      for (int i = 0; i < 5; i++)
      begin
         rck("data after reset", ofs(i), msk(i));
         rck("dir after reset", ofs(i) + 8'h01, msk(i));
         check("oe after reset", oe[i], i == 4 ? 8'h1c : 8'h00);
         check("pull after reset", pu[i], i == 4 ? 8'h03 : 8'hff);
      end
   endtask : t_reset_state
   task automatic t_write_drive;
      for (int i = 0; i < 5; i++)
      begin
         wr(ofs(i) + 8'h01, 8'h00);
         wr(ofs(i), 8'ha5);
      end
      wr(8'h11, 8'h5a);
      wait_n(2);
      for (int i = 0; i < 5; i++)
      begin
         rck("latch read", ofs(i), 8'ha5 & msk(i));
         check("out enable", oe[i], i == 2 ? 8'hfe : msk(i));
         check("out level", po[i], i == 2 ? 8'ha4 : 8'ha5 & msk(i));
      end
      rck("unmapped read", 8'h11, 8'h00);
   endtask : t_write_drive
   task automatic t_pad_input;
      kbio_byte_type v;
      for (int i = 0; i < 5; i++)
      begin
         key_en[i] = 1'b1;
         wr(ofs(i) + 8'h01, 8'hff);
      end
      for (int k = 0; k < 2; k++)
      begin
         v = (k == 0) ? 8'h3c : 8'hc3;
         for (int i = 0; i < 5; i++)
            key_val[i] = v;
         wait_n(3);
         for (int i = 0; i < 5; i++)
         begin
            rck("pad read", ofs(i), i == 4 ? 8'h04 | (v & 8'h03) : v);
            check("in enable", oe[i], i == 4 ? 8'h1c : 8'h00);
            check("in pull", pu[i], i == 4 ? 8'h03 : 8'hff);
         end
      end
   endtask : t_pad_input
   task automatic t_rmw;
      kbio_byte_type d;
      key_val[0] = 8'h00;
      wr(ofs(0) + 8'h01, 8'hf0);
      wr(ofs(0), 8'h55);
      wait_n(3);
      rdx(ofs(0), d);
      check("mixed read", d, 8'h05);
      wr(ofs(0), d | 8'h02);
      wait_n(2);
      check("mixed oe", oe[0], 8'h0f);
      check("bit set out", po[0] & 8'h0f, 8'h07);
      wr(ofs(0) + 8'h01, 8'h00);
      rck("bit set latch", ofs(0), 8'h07);
      wr(ofs(0) + 8'h01, 8'hff);
   endtask : t_rmw
   task automatic t_irq;
      for (int s = 0; s < 2; s++)
      begin
         wr(ofs(4), 8'h1e | 8'(s));
         key_val[2][2] = s[0];
         wait_n(6);
         ack_irq();
         key_val[2][2] = ~s[0];
         wait_n(6);
         check("wrong edge", {7'h0, ext_irq_req}, 8'h00);
         key_val[2][2] = s[0];
         wait_n(5);
         check("irq edge", {7'h0, ext_irq_req}, 8'h01);
         wait_n(3);
         check("irq held", {7'h0, ext_irq_req}, 8'h01);
         ack_irq();
         check("irq cleared", {7'h0, ext_irq_req}, 8'h00);
      end
   endtask : t_irq
   task automatic wake_try(input int p, b, input logic h, input int exp);
      int n;
      n = 0;
      halt = h;
      key_val[p] = 8'hff;
      wait_n(4);
      key_val[p][b] = 1'b0;
      repeat (6)
      begin
         @(negedge sys_clk);
         n += int'(wake === 1'b1);
      end
      halt = 1'b0;
      check("wake pulses", 8'(n), 8'(exp));
   endtask : wake_try
   task automatic t_resets;
      wr(ofs(0) + 8'h01, 8'h00);
      wr(ofs(0), 8'h3c);
      halt = 1'b1;
      wait_n(8);
      halt = 1'b0;
      rck("warm keeps data", ofs(0), 8'h3c);
      rck("warm keeps dir", ofs(0) + 8'h01, 8'h00);
      for (int i = 0; i < 5; i++)
         key_en[i] = 1'b0;
      @(negedge sys_clk);
      chip_reset = 1'b1;
      @(negedge sys_clk);
      chip_reset = 1'b0;
      wait_n(2);
      t_reset_state();
   endtask : t_resets

   // ======================================================================
   // Verdict, hang guard and main sequence
   task automatic final_report;
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   // Cuts a hung run short well beyond the expected length.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         final_report();
      end
   end

   // Reset, then every scenario in turn.
   initial
   begin
      rst_b = 1'b0;
      {chip_reset, halt, mem_wr, mem_rd, ext_irq_ack} = 5'h00;
      mem_addr = 8'h00;
      mem_wdata = 8'h00;
      for (int i = 0; i < 5; i++)
      begin
         key_val[i] = 8'h00;
         key_en[i] = 1'b0;
      end
      wait_n(12);
      rst_b = 1'b1;
      t_reset_state();
      t_write_drive();
      t_pad_input();
      t_rmw();
      t_irq();
      wake_try(0, 0, 1'b1, 1);
      wake_try(0, 7, 1'b1, 1);
      wake_try(2, 3, 1'b1, 1);
      wake_try(2, 4, 1'b1, 0);
      wake_try(1, 5, 1'b1, 0);
      wake_try(0, 2, 1'b0, 0);
      t_resets();
      final_report();
   end
endmodule : kbio_ports_tb
